/* hw/periph_bank_regs.vh */
// Register offsets, field positions, reset values and timing counts for the bank controller
`ifndef PERIPH_BANK_REGS_VH
`define PERIPH_BANK_REGS_VH
// Register indices; byte address is four times the index
`define IDX_BANK0_CONFIG 8'h00
`define IDX_LOGIC_BANK_CONFIG 8'h02
`define IDX_NAND_BANK_CONFIG 8'h03
`define IDX_BANK0_ACCESS_TIMING 8'h10
`define IDX_LOGIC_BANK_ACCESS_TIMING 8'h12
`define IDX_NAND_BANK_ACCESS_TIMING 8'h13
`define IDX_CTRL_STATUS 8'h20
// Reset values
`define RST_BANK0_CONFIG 32'hfc0d_a000
`define RST_LOGIC_BANK_CONFIG 32'hc003_8000
`define RST_NAND_BANK_CONFIG 32'hd00f_c000
`define RST_BANK0_ACCESS_TIMING 32'h0301_7300
`define RST_LOGIC_BANK_ACCESS_TIMING 32'h2481_4580
`define RST_NAND_BANK_ACCESS_TIMING 32'h7f8f_fe80
// Field positions, bit 0 is the word's MSB, so doc bit n sits at vector bit 31-n
`define AP_BURST_ALLOW 31
`define AP_WAIT_HI 30
`define AP_WAIT_LO 23
`define AP_SEL_HI 19
`define AP_SEL_LO 18
`define AP_RD_HI 17
`define AP_RD_LO 16
`define AP_WON_HI 15
`define AP_WON_LO 14
`define AP_WOFF_HI 13
`define AP_WOFF_LO 12
`define AP_HOLD_HI 11
`define AP_HOLD_LO 9
`define AP_READY_USE 8
`define AP_READY_SAME 7
`define AP_BYTE_POLICY 6
`define AP_PARITY_ON 5
`define CF_BASE_HI 31
`define CF_BASE_LO 20
`define CF_SIZE_HI 19
`define CF_SIZE_LO 17
`define CF_USAGE_HI 16
`define CF_USAGE_LO 15
`define CF_WIDTH_HI 14
`define CF_WIDTH_LO 13
// Usage and width codes
`define USAGE_READ_BIT 1
`define USAGE_WRITE_BIT 0
`define WIDTH_32 2'b10
// Ready wait limit; accesses stalled longer than this end with a timeout flag
`define READY_TIMEOUT_US 100
`define CLK_MHZ 25
`define READY_TIMEOUT_CYC (`READY_TIMEOUT_US * `CLK_MHZ)
`endif

/* hw/bank_decode.v */
// Address window decode for one chip-select bank
`timescale 1ns/1ps
module bank_decode (
  input wire [31:0] config_word,
  input wire [31:0] addr,
  input wire is_write,
  output reg hit,
  output reg allowed
);
  `include "periph_bank_regs.vh"
  reg [7:0] size_bits;
  reg [31:0] mask;
  always @* begin
    case (config_word[`CF_SIZE_HI:`CF_SIZE_LO])
      3'd0: size_bits = 8'd20;
      3'd1: size_bits = 8'd21;
      3'd2: size_bits = 8'd22;
      3'd3: size_bits = 8'd23;
      3'd4: size_bits = 8'd24;
      3'd5: size_bits = 8'd25;
      3'd6: size_bits = 8'd26;
      default: size_bits = 8'd27;
    endcase
    mask = 32'hffff_ffff << size_bits;
    // Base gives address bits 31:20; size masks the low part of it
    hit = ((addr & mask) == ({config_word[`CF_BASE_HI:`CF_BASE_LO], 20'h0_0000} & mask));
    allowed = is_write ? config_word[15 + `USAGE_WRITE_BIT]
                       : config_word[15 + `USAGE_READ_BIT];
  end
endmodule // bank_decode

/* hw/access_timer.v */
// Down counter for the timed phases of an access
`timescale 1ns/1ps
module access_timer #(
  parameter WIDTH = 8
) (
  input wire clk_sys,
  input wire srst,
  input wire load,
  input wire [WIDTH-1:0] value,
  output wire zero
);
  reg [WIDTH-1:0] count;
  always @(posedge clk_sys) begin
    if (srst) begin
      count <= {WIDTH{1'b0}};
    end else if (load) begin
      count <= value;
    end else if (count != {WIDTH{1'b0}}) begin
      count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
  assign zero = (count == {WIDTH{1'b0}});
endmodule // access_timer

/* hw/peripheral_bank_timing_ctrl.v */
// Chip-select bank controller for asynchronous peripheral devices
// Overview of operation
// - Access timing bits 1-8 hold a wait count that lengthens each access by that many cycles.
// - Timing bits 12-13 delay chip select by 0 to 3 cycles from the start of an access.
// - Timing bits 14-15 delay read strobe after chip select on reads.
// - Timing bits 16-17 and 18-19 set when write byte strobes turn on and off.
// - Timing bits 20-22 give a 0 to 7 cycle hold after each access before the next starts.
// - With ready use on and same-cycle off, the transfer ends one cycle after ready is seen.
// - With ready use and same-cycle on, the transfer ends in the cycle ready is seen.
// - With byte strobe policy clear, write byte strobes are active only on writes.
// - Parity on clear means no parity check; bit 0 allows bursts, clear gives single accesses; the code never checks parity and issues single accesses only.
// - Config bits 0-11 give the window base address the bank answers at.
// - Config bits 12-14 give the window size, 001 is 2 MB, 110 is 64 MB, 111 is 128 MB.
// - Config bits 15-16 give the allowed access types, 11 allows reads and writes.
// - Config bits 17-18 give the data width, 10 is 32 bits and any other code 16 bits.
`timescale 1ns/1ps
`include "periph_bank_regs.vh"
module peripheral_bank_timing_ctrl #(
  parameter NUM_BANKS = 3,
  parameter READY_TIMEOUT = `READY_TIMEOUT_CYC
) (
  input wire clk_sys,
  input wire srst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire req_valid,
  input wire req_write,
  input wire [31:0] req_addr,
  input wire [31:0] req_wdata,
  input wire [3:0] req_be,
  output reg req_done,
  output reg req_error,
  output reg [31:0] req_rdata,
  output reg [31:0] periph_addr,
  output reg [31:0] periph_data_out,
  output reg periph_data_oe,
  input wire [31:0] periph_data_in,
  output reg [2:0] periph_select_n,
  output reg periph_read_strobe_n,
  output reg [1:0] periph_write_byte_strobes_n,
  input wire periph_ready_in,
  output reg periph_wide
);
  localparam ST_IDLE = 3'd0;
  localparam ST_SETUP = 3'd1;
  localparam ST_WAIT = 3'd2;
  localparam ST_READY = 3'd3;
  localparam ST_LATE = 3'd4;
  localparam ST_HOLD = 3'd5;
  localparam ST_TRAIL = 3'd6;

  reg [31:0] config_reg [0:NUM_BANKS-1];
  reg [31:0] timing_reg [0:NUM_BANKS-1];
  reg [2:0] state;
  reg [1:0] bank;
  reg is_write;
  reg [7:0] phase;
  reg timeout_flag;
  reg unmapped_flag;
  reg [31:0] tmo_count;
  wire [NUM_BANKS-1:0] hit;
  wire [NUM_BANKS-1:0] allowed;
  wire timer_zero;
  reg timer_load;
  reg [7:0] timer_value;
  reg [1:0] hit_bank;
  reg any_hit;
  reg [31:0] next_reg_rdata;
  // Lanes held for the whole access; the requester may move them
  reg [1:0] byte_lanes;
  integer i;
  integer j;

  // Fields of the active bank, MSB-first numbering mapped onto vector bits
  wire [31:0] ap = timing_reg[bank];
  wire [7:0] wait_cycles [0:NUM_BANKS-1];
  wire [1:0] select_on_delay = ap[`AP_SEL_HI:`AP_SEL_LO];
  wire [1:0] read_strobe_delay = ap[`AP_RD_HI:`AP_RD_LO];
  wire [1:0] write_strobe_on_delay = ap[`AP_WON_HI:`AP_WON_LO];
  wire [1:0] write_strobe_off_delay = ap[`AP_WOFF_HI:`AP_WOFF_LO];
  wire [2:0] hold_cycles = ap[`AP_HOLD_HI:`AP_HOLD_LO];
  wire ready_use = ap[`AP_READY_USE];
  wire ready_same_cycle = ap[`AP_READY_SAME];
  wire byte_strobe_policy = ap[`AP_BYTE_POLICY];

  function [31:0] reset_config;
    input integer n;
    begin
      case (n)
        0: reset_config = `RST_BANK0_CONFIG;
        1: reset_config = `RST_LOGIC_BANK_CONFIG;
        default: reset_config = `RST_NAND_BANK_CONFIG;
      endcase
    end
  endfunction

  function [31:0] reset_timing;
    input integer n;
    begin
      case (n)
        0: reset_timing = `RST_BANK0_ACCESS_TIMING;
        1: reset_timing = `RST_LOGIC_BANK_ACCESS_TIMING;
        default: reset_timing = `RST_NAND_BANK_ACCESS_TIMING;
      endcase
    end
  endfunction

  // Bank index for a register index, or NUM_BANKS when none
  function [1:0] bank_of;
    input [7:0] idx;
    begin
      case (idx)
        `IDX_BANK0_CONFIG, `IDX_BANK0_ACCESS_TIMING: bank_of = 2'd0;
        `IDX_LOGIC_BANK_CONFIG, `IDX_LOGIC_BANK_ACCESS_TIMING: bank_of = 2'd1;
        `IDX_NAND_BANK_CONFIG, `IDX_NAND_BANK_ACCESS_TIMING: bank_of = 2'd2;
        default: bank_of = 2'd3;
      endcase
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g = g + 1) begin : dec
      bank_decode u_dec (
        .config_word(config_reg[g]),
        .addr(req_addr),
        .is_write(req_write),
        .hit(hit[g]),
        .allowed(allowed[g])
      );
    end
  endgenerate

  // Wait count per bank; idle must load the bank being entered, not the last one
  generate
    for (g = 0; g < NUM_BANKS; g = g + 1) begin : waits
      assign wait_cycles[g] = timing_reg[g][`AP_WAIT_HI:`AP_WAIT_LO];
    end
  endgenerate

  access_timer #(.WIDTH(8)) u_timer (
    .clk_sys(clk_sys),
    .srst(srst),
    .load(timer_load),
    .value(timer_value),
    .zero(timer_zero)
  );

  // Lowest-numbered bank wins if windows overlap
  always @* begin
    hit_bank = 2'd0;
    any_hit = 1'b0;
    for (j = NUM_BANKS - 1; j >= 0; j = j - 1) begin
      if (hit[j]) begin
        hit_bank = j[1:0];
        any_hit = 1'b1;
      end
    end
  end

  // Register file; the bus is never stalled
  always @(posedge clk_sys) begin
    if (srst) begin
      for (i = 0; i < NUM_BANKS; i = i + 1) begin
        config_reg[i] <= reset_config(i);
        timing_reg[i] <= reset_timing(i);
      end
      reg_rdata <= 32'h0000_0000;
    end else begin
      if (reg_wr && bank_of(reg_addr) != 2'd3) begin
        if (reg_addr[4])
          timing_reg[bank_of(reg_addr)] <= reg_wdata;
        else
          config_reg[bank_of(reg_addr)] <= reg_wdata;
      end
      reg_rdata <= next_reg_rdata;
    end
  end

  // Read mux; the registered copy stands only in the cycle after the strobe
  always @* begin
    next_reg_rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == `IDX_CTRL_STATUS) begin
        next_reg_rdata = {26'h000_0000, unmapped_flag, timeout_flag, state == ST_IDLE, state};
      end else if (bank_of(reg_addr) != 2'd3) begin
        if (reg_addr[4]) begin
          next_reg_rdata = timing_reg[bank_of(reg_addr)];
        end else begin
          next_reg_rdata = config_reg[bank_of(reg_addr)];
        end
      end
    end
  end

  // Timer load decisions for each phase transition
  always @* begin
    timer_load = 1'b0;
    timer_value = 8'h00;
    case (state)
      ST_IDLE: begin
        if (req_valid && any_hit && allowed[hit_bank]) begin
          timer_load = 1'b1;
          timer_value = wait_cycles[hit_bank];
        end
      end
      ST_READY: begin
        if (periph_ready_in && ready_same_cycle) begin
          timer_load = 1'b1;
          timer_value = {5'h00, hold_cycles};
        end
      end
      ST_WAIT, ST_LATE: begin
        if (timer_zero && !(state == ST_WAIT && ready_use)) begin
          timer_load = 1'b1;
          timer_value = {5'h00, hold_cycles};
        end
      end
      default: begin
        timer_load = 1'b0;
      end
    endcase
  end

  // Access sequencer; phase counts cycles since the access began
  always @(posedge clk_sys) begin
    if (srst) begin
      state <= ST_IDLE;
      bank <= 2'd0;
      is_write <= 1'b0;
      phase <= 8'h00;
      req_done <= 1'b0;
      req_error <= 1'b0;
      req_rdata <= 32'h0000_0000;
      periph_addr <= 32'h0000_0000;
      periph_data_out <= 32'h0000_0000;
      periph_data_oe <= 1'b0;
      periph_select_n <= 3'b111;
      periph_read_strobe_n <= 1'b1;
      periph_write_byte_strobes_n <= 2'b11;
      periph_wide <= 1'b0;
      byte_lanes <= 2'b11;
      timeout_flag <= 1'b0;
      unmapped_flag <= 1'b0;
      tmo_count <= 32'h0000_0000;
    end else begin
      req_done <= 1'b0;
      req_error <= 1'b0;
      if (phase != 8'hff)
        phase <= phase + 8'h01;
      case (state)
        ST_IDLE: begin
          phase <= 8'h00;
          if (req_valid) begin
            if (any_hit && allowed[hit_bank]) begin
              // Single accesses only; burst allow is stored but bursts are never issued
              bank <= hit_bank;
              is_write <= req_write;
              byte_lanes <= req_be[1:0];
              periph_addr <= req_addr;
              periph_data_out <= req_wdata;
              periph_data_oe <= req_write;
              periph_wide <= (config_reg[hit_bank][`CF_WIDTH_HI:`CF_WIDTH_LO] == `WIDTH_32);
              tmo_count <= 32'h0000_0000;
              timeout_flag <= 1'b0;
              state <= ST_SETUP;
            end else begin
              req_done <= 1'b1;
              req_error <= 1'b1;
              unmapped_flag <= 1'b1;
              // Through hold, so a request still up at the next edge is not refused twice
              state <= ST_HOLD;
            end
          end
        end
        ST_SETUP, ST_WAIT, ST_READY, ST_TRAIL, ST_LATE: begin
          if (phase >= {6'h00, select_on_delay})
            periph_select_n[bank] <= 1'b0;
          if (!is_write && phase >= {6'h00, select_on_delay} + {6'h00, read_strobe_delay})
            periph_read_strobe_n <= 1'b0;
          if (is_write && !byte_strobe_policy) begin
            if (phase >= {6'h00, write_strobe_on_delay} && state != ST_LATE)
              periph_write_byte_strobes_n <= ~byte_lanes;
          end else if (byte_strobe_policy) begin
            periph_write_byte_strobes_n <= ~byte_lanes;
          end
          if (state == ST_SETUP)
            state <= ST_WAIT;
          if (state == ST_WAIT && timer_zero) begin
            if (ready_use)
              state <= ST_READY;
            else
              state <= ST_LATE;
          end
          if (state == ST_READY) begin
            tmo_count <= tmo_count + 32'h0000_0001;
            if (periph_ready_in) begin
              if (ready_same_cycle) begin
                req_rdata <= periph_data_in;
                state <= ST_LATE;
              end else begin
                state <= ST_TRAIL;
              end
            end else if (tmo_count >= READY_TIMEOUT) begin
              timeout_flag <= 1'b1;
              state <= ST_LATE;
            end
          end
          // Ready was taken last cycle; the transfer lands one cycle later
          if (state == ST_TRAIL) begin
            req_rdata <= periph_data_in;
            state <= ST_LATE;
          end
          // Final phase: strobes off after the off delay, then hold
          if (state == ST_LATE) begin
            if (phase >= {6'h00, write_strobe_off_delay} || !is_write)
              periph_write_byte_strobes_n <= 2'b11;
            if (!ready_use)
              req_rdata <= periph_data_in;
            periph_read_strobe_n <= 1'b1;
            periph_select_n <= 3'b111;
            periph_data_oe <= 1'b0;
            req_done <= 1'b1;
            req_error <= timeout_flag;
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          periph_write_byte_strobes_n <= 2'b11;
          if (timer_zero)
            state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // peripheral_bank_timing_ctrl

/* tb/periph_bank_sva.sv */
// Port assertions for the bank controller
`timescale 1ns/1ps
module periph_bank_sva (
  input wire clk_sys,
  input wire srst,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire req_done,
  input wire req_error,
  input wire [2:0] periph_select_n,
  input wire periph_read_strobe_n,
  input wire [1:0] periph_write_byte_strobes_n,
  input wire periph_data_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data not zero");
  chk_read_no_wstrb: assert property (!periph_read_strobe_n |-> &periph_write_byte_strobes_n)
    else $error("write strobe during read");
  chk_read_no_drive: assert property (!periph_read_strobe_n |-> !periph_data_oe)
    else $error("data driven during read");
  chk_one_select: assert property ($onehot0(~periph_select_n))
    else $error("two selects low");
  chk_strobe_in_sel: assert property (
    (!periph_read_strobe_n || !(&periph_write_byte_strobes_n)) |-> !(&periph_select_n))
    else $error("strobe without select");
  chk_done_pulse: assert property (req_done |=> !req_done)
    else $error("done longer than one cycle");
  chk_error_done: assert property (req_error |-> req_done)
    else $error("error without done");
  chk_done_after_sel: assert property (
    req_done && !req_error |-> $past(periph_select_n) != 3'b111)
    else $error("done without a selected bank");
  chk_reset_idle: assert property (
    $past(srst) |-> &periph_select_n && periph_read_strobe_n && !req_done)
    else $error("bus not idle after reset");
  cover property (req_done && req_error);
  cover property (!periph_read_strobe_n);
  cover property (!(&periph_write_byte_strobes_n));
endmodule // periph_bank_sva

/* tb/periph_device_model.sv */
// Behavioural asynchronous device on the peripheral bus
`timescale 1ns/1ps
module periph_device_model #(
  parameter logic [31:0] PAT = 32'h5a5a_a5a5
) (
  input wire clk_sys,
  input wire [2:0] periph_select_n,
  input wire periph_read_strobe_n,
  input wire [1:0] periph_write_byte_strobes_n,
  input wire [31:0] periph_addr,
  input wire [31:0] periph_data_out,
  input wire [7:0] ready_lat,
  output logic [31:0] periph_data_in = 32'h0000_0000,
  output logic periph_ready_in = 1'b0,
  output logic [31:0] last_write = 32'h0000_0000
);
  logic [7:0] sel_cnt = 8'h00;
  always @(posedge clk_sys) begin
    sel_cnt <= (&periph_select_n) ? 8'h00 : sel_cnt + {7'h00, sel_cnt != 8'hff};
    // Held until the select lets go, so a late sample still sees it
    periph_ready_in <= !(&periph_select_n) && sel_cnt >= ready_lat;
    // Released bus toggles so stale data never looks valid
    if (!(&periph_select_n) && !periph_read_strobe_n) begin
      periph_data_in <= periph_addr ^ PAT;
    end else begin
      periph_data_in <= ~periph_data_in;
    end
    if (!(&periph_write_byte_strobes_n)) begin
      last_write <= periph_data_out;
    end
  end
endmodule // periph_device_model

/* tb/peripheral_bank_timing_ctrl_tb.sv */
// Self-checking bench for the bank controller
`timescale 1ns/1ps
`include "periph_bank_regs.vh"
module peripheral_bank_timing_ctrl_tb;
  localparam logic [31:0] PAT = 32'h5a5a_a5a5;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [31:0] req_addr = 32'h0000_0000;
  logic [31:0] req_wdata = 32'h0000_0000;
  logic [7:0] ready_lat = 8'h02;
  wire [31:0] reg_rdata, req_rdata, periph_addr, periph_data_out, periph_data_in, last_write;
  wire req_done, req_error, periph_data_oe, periph_read_strobe_n, periph_ready_in, periph_wide;
  wire [2:0] periph_select_n;
  wire [1:0] periph_write_byte_strobes_n;
  int failures = 0;
  int total_checks = 0;
  logic [31:0] regs_m [0:255];
  logic [7:0] idx [0:5] = '{`IDX_BANK0_CONFIG, `IDX_LOGIC_BANK_CONFIG, `IDX_NAND_BANK_CONFIG,
    `IDX_BANK0_ACCESS_TIMING, `IDX_LOGIC_BANK_ACCESS_TIMING, `IDX_NAND_BANK_ACCESS_TIMING};
  logic [31:0] ta [0:8] = '{32'hd000_0040, 32'hd7ff_fffc, 32'hd800_0000, 32'hfc00_0000,
    32'hffff_fffc, 32'hfbff_fffc, 32'hc000_0100, 32'hc01f_fff0, 32'hc020_0000};
  logic [2:0] sel_and;
  logic wide_seen;
  always #20 clk_sys = ~clk_sys;
  peripheral_bank_timing_ctrl #(.READY_TIMEOUT(100)) dut (.clk_sys(clk_sys), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_be(4'hf), .req_done(req_done), .req_error(req_error),
    .req_rdata(req_rdata), .periph_addr(periph_addr), .periph_data_out(periph_data_out),
    .periph_data_oe(periph_data_oe), .periph_data_in(periph_data_in),
    .periph_select_n(periph_select_n), .periph_read_strobe_n(periph_read_strobe_n),
    .periph_write_byte_strobes_n(periph_write_byte_strobes_n),
    .periph_ready_in(periph_ready_in), .periph_wide(periph_wide));
  periph_device_model #(.PAT(PAT)) dev (.clk_sys(clk_sys), .periph_select_n(periph_select_n),
    .periph_read_strobe_n(periph_read_strobe_n),
    .periph_write_byte_strobes_n(periph_write_byte_strobes_n), .periph_addr(periph_addr),
    .periph_data_out(periph_data_out), .ready_lat(ready_lat), .periph_data_in(periph_data_in),
    .periph_ready_in(periph_ready_in), .last_write(last_write));
  always @(posedge clk_sys) begin
    if (!(&periph_select_n)) begin
      sel_and <= sel_and & periph_select_n;
      wide_seen <= periph_wide;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    if (a inside {idx}) regs_m[a] = v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(reg_rdata, regs_m[a]);
  endtask
  // Request drops at the edge that samples done
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic e, output logic [31:0] q, output int n);
    n = 0;
    e = 1'b1;
    sel_and = 3'b111;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    while (n < 2000) begin
      @(posedge clk_sys);
      n++;
      if (req_done === 1'b1) begin
        req_valid <= 1'b0;
        e = req_error;
        q = req_rdata;
        break;
      end
    end
    if (n >= 2000) begin
      failures++;
      finish_test;
    end
    repeat (10) @(posedge clk_sys);
  endtask
  function automatic int bank_of(input logic [31:0] a);
    logic [31:0] c;
    bank_of = -1;
    for (int k = 0; k < 3; k++) begin
      c = regs_m[idx[k]];
      if (a - {c[31:20], 20'h00000} < (32'h0010_0000 << c[19:17])) bank_of = k;
    end
  endfunction
  task automatic finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    failures++;
    finish_test;
  end
  initial begin
    int i, p, k, n0, n1;
    logic e;
    logic [31:0] q, d, m, c;
    for (i = 0; i < 256; i++) regs_m[i] = 32'h0000_0000;
    regs_m[idx[0]] = `RST_BANK0_CONFIG;
    regs_m[idx[1]] = `RST_LOGIC_BANK_CONFIG;
    regs_m[idx[2]] = `RST_NAND_BANK_CONFIG;
    regs_m[idx[3]] = `RST_BANK0_ACCESS_TIMING;
    regs_m[idx[4]] = `RST_LOGIC_BANK_ACCESS_TIMING;
    regs_m[idx[5]] = `RST_NAND_BANK_ACCESS_TIMING;
    void'($urandom(32'hca56_7a61));
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    // Random values stay inside the documented fields
    for (i = 0; i < 6; i++) begin
      m = (i > 2) ? 32'hff8f_ffe0 : 32'hffff_e000;
      d = regs_m[idx[i]];
      rd(idx[i]);
      wr(idx[i], $urandom() & m);
      rd(idx[i]);
      wr(idx[i], d);
    end
    wr(8'h05, $urandom());
    rd(8'h05);
    for (p = 0; p < 2; p++) begin
      for (i = 0; i < 18; i++) begin
        d = $urandom();
        acc(i[0], ta[i / 2], d, e, q, n0);
        k = bank_of(ta[i / 2]);
        c = (k < 0) ? 32'h0000_0000 : regs_m[idx[k]];
        chk(e, (k < 0) || !c[i[0] ? `CF_USAGE_LO : `CF_USAGE_HI]);
        if (k >= 0 && !e) begin
          m = (c[`CF_WIDTH_HI:`CF_WIDTH_LO] == `WIDTH_32) ? 32'hffff_ffff : 32'h0000_ffff;
          chk(sel_and, 3'b111 ^ (3'b001 << k));
          chk(wide_seen, m[31]);
          chk((i[0] ? last_write : q) & m, (i[0] ? d : ta[i / 2] ^ PAT) & m);
          if (k == 2) chk(n0 > 255, 1'b1);
        end
      end
      wr(idx[1], `RST_LOGIC_BANK_CONFIG & ~(32'h1 << `CF_USAGE_LO));
    end
    wr(idx[1], `RST_LOGIC_BANK_CONFIG);
    ready_lat <= 8'd30;
    for (p = 0; p < 2; p++) begin
      wr(idx[4], (`RST_LOGIC_BANK_ACCESS_TIMING & ~32'h7f80_0080) | (32'h4 << `AP_WAIT_LO)
        | (p << `AP_READY_SAME));
      acc(1'b0, 32'hc000_0008, 32'h0000_0000, e, q, n1);
      if (p == 0) n0 = n1;
    end
    chk(n0, n1 + 1);
    // Device answers only once its select count reaches 255: the access must end on the ready limit first, with an error
    ready_lat <= 8'hff;
    acc(1'b0, 32'hc000_0010, 32'h0000_0000, e, q, n1);
    chk(e, 1'b1);
    regs_m[`IDX_CTRL_STATUS] = 32'h0000_0038;
    rd(`IDX_CTRL_STATUS);
    finish_test;
  end
endmodule // peripheral_bank_timing_ctrl_tb
bind peripheral_bank_timing_ctrl periph_bank_sva sva_i (.clk_sys(clk_sys), .srst(srst),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_done(req_done), .req_error(req_error),
  .periph_select_n(periph_select_n), .periph_read_strobe_n(periph_read_strobe_n),
  .periph_write_byte_strobes_n(periph_write_byte_strobes_n), .periph_data_oe(periph_data_oe));
